// ==== acltw_regs.svh ====
// register offsets, reset values and timing constants of the converter setup block
`ifndef ACLTW_REGS_SVH
`define ACLTW_REGS_SVH

`define ACLTW_MAX_LOW_ADDR 8'h22
`define ACLTW_MIN_HIGH_ADDR 8'h23
`define ACLTW_MIN_LOW_ADDR 8'h24
`define ACLTW_DELAY_ADDR 8'h25
`define ACLTW_WAIT_ADDR 8'h26

`define ACLTW_MAX_LOW_RESET 8'h00
`define ACLTW_MIN_HIGH_RESET 8'h00
`define ACLTW_MIN_LOW_RESET 8'h00
`define ACLTW_DELAY_RESET 8'h00
`define ACLTW_WAIT_RESET 8'h00

`define ACLTW_HIGH_BITS_MASK 8'h07
`define ACLTW_TRIG_SEL_BIT 7
`define ACLTW_EDGE_BIT 6
`define ACLTW_HOLDOFF_BIT 5
`define ACLTW_REPEAT_BIT 4
`define ACLTW_DELAY_LSB 0
`define ACLTW_A2_PULL_LSB 6
`define ACLTW_ID_PULL_LSB 4
`define ACLTW_GAP_LSB 0

`define ACLTW_CLK_PERIOD_NS 10
`define ACLTW_DELAY_STEP_NS 5000
`define ACLTW_GAP_STEP_NS 20000
`define ACLTW_DELAY_STEP_CYCLES (`ACLTW_DELAY_STEP_NS / `ACLTW_CLK_PERIOD_NS)
`define ACLTW_GAP_STEP_CYCLES (`ACLTW_GAP_STEP_NS / `ACLTW_CLK_PERIOD_NS)

`endif

// ==== acltw_pkg.sv ====
// types shared by the converter setup block
package acltw_pkg;
  typedef enum logic [1:0] {ACLTW_IDLE, ACLTW_DELAY, ACLTW_CONVERT, ACLTW_GAP} acltw_state_t;
  typedef logic [10:0] acltw_word_t;
  typedef logic [21:0] acltw_count_t;
endpackage : acltw_pkg

// ==== acltw_timer_if.sv ====
// carrier between the sequencer and one countdown timer
interface acltw_timer_if;
  import acltw_pkg::*;
  logic load;
  acltw_count_t cycles;
  logic done;
  modport ctrl (output load, output cycles, input done);
  modport timer (input load, input cycles, output done);
endinterface : acltw_timer_if

// ==== acltw_timer.sv ====
// countdown timer: done pulses exactly cycles clocks after load (one clock when cycles is zero)
module acltw_timer
  import acltw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control side
  acltw_timer_if.timer tif
);
  acltw_count_t count;
  acltw_count_t next_count;
  logic run;
  logic next_run;
  logic done_q;
  logic next_done;

  // a fresh load restarts the count, so a late load never merges with a running one
  always_comb
  begin
    next_count = count;
    next_run = run;
    next_done = 1'b0;
    if (tif.load)
    begin
      if (tif.cycles <= 22'h000001)
      begin
        next_done = 1'b1;
        next_run = 1'b0;
      end
      else
      begin
        next_count = tif.cycles - 22'h000001;
        next_run = 1'b1;
      end
    end
    else if (run)
    begin
      next_count = count - 22'h000001;
      if (count == 22'h000001)
      begin
        next_done = 1'b1;
        next_run = 1'b0;
      end
    end
  end

  // registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count <= 22'h000000;
      run <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      count <= next_count;
      run <= next_run;
      done_q <= next_done;
    end
  end

  assign tif.done = done_q;
endmodule : acltw_timer

// ==== acltw_top.sv ====
// converter limit, pin trigger, delay and sample gap configuration with its sequencer
// Operation
// [RL1] pin transitions start conversions when selected
// [RL2] pin trigger delay, code times 5us
// [RL3] coded wait between samples in multi-mode
// [RL4] wait code resets to zero
// [RL5] eleven-bit limits compared against results
// [RL6] result is eleven-bit unsigned value
`include "acltw_regs.svh"
module acltw_top
  import acltw_pkg::*;
#(
  parameter int DELAY_STEP_CYCLES = `ACLTW_DELAY_STEP_CYCLES,
  parameter int GAP_STEP_CYCLES = `ACLTW_GAP_STEP_CYCLES
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // byte register port from the serial host engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // neighbouring settings
  input wire logic [2:0] max_limit_high_bits,
  input wire logic multi_sample_mode,
  input wire logic more_samples,
  // trigger sources
  input wire logic sw_start,
  input wire logic third_general_pin,
  // converter core
  input wire logic conv_done,
  input wire logic [10:0] conv_result,
  output logic conv_start,
  output logic [10:0] result,
  output logic above_max,
  output logic below_min,
  // analog pull-up settings
  output logic [1:0] analog2_pullup_code,
  output logic [1:0] pack_id_pullup_code
);
  logic [7:0] max_low;
  logic [7:0] min_high;
  logic [7:0] min_low;
  logic [7:0] delay_ctl;
  logic [7:0] wait_ctl;
  logic [7:0] next_rdata;
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic pin_edge;
  logic trig_armed;
  logic next_armed;
  acltw_state_t state;
  acltw_state_t next_state;
  logic next_start;
  acltw_word_t next_result;
  logic next_above;
  logic next_below;
  acltw_word_t max_word;
  acltw_word_t min_word;
  acltw_timer_if delay_tif ();
  acltw_timer_if gap_tif ();

  // join high bits and low byte into one limit word
  function automatic acltw_word_t limit_word(input logic [7:0] hi, input logic [7:0] lo);
    limit_word = {hi[2:0], lo};
  endfunction : limit_word

  // multiples of the 20us step for each gap code
  function automatic logic [10:0] gap_mult(input logic [3:0] code);
    case (code)
      4'h0: gap_mult = 11'h000;
      4'h1: gap_mult = 11'h001;
      4'h2: gap_mult = 11'h002;
      4'h3: gap_mult = 11'h003;
      4'h4: gap_mult = 11'h004;
      4'h5: gap_mult = 11'h008;
      4'h6: gap_mult = 11'h00c;
      4'h7: gap_mult = 11'h010;
      4'h8: gap_mult = 11'h020;
      4'h9: gap_mult = 11'h040;
      4'ha: gap_mult = 11'h060;
      4'hb: gap_mult = 11'h080;
      4'hc: gap_mult = 11'h100;
      4'hd: gap_mult = 11'h200;
      4'he: gap_mult = 11'h300;
      default: gap_mult = 11'h400;
    endcase
  endfunction : gap_mult

  // [RL5] limit words formed
  assign max_word = limit_word({5'h00, max_limit_high_bits}, max_low);
  assign min_word = limit_word(min_high, min_low);
  assign analog2_pullup_code = wait_ctl[`ACLTW_A2_PULL_LSB +: 2];
  assign pack_id_pullup_code = wait_ctl[`ACLTW_ID_PULL_LSB +: 2];

  // register writes; upper bits of the minimum high byte are reserved and kept zero
  // [RL4] wait code resets zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      max_low <= `ACLTW_MAX_LOW_RESET;
      min_high <= `ACLTW_MIN_HIGH_RESET;
      min_low <= `ACLTW_MIN_LOW_RESET;
      delay_ctl <= `ACLTW_DELAY_RESET;
      wait_ctl <= `ACLTW_WAIT_RESET;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        `ACLTW_MAX_LOW_ADDR: max_low <= reg_wdata;
        `ACLTW_MIN_HIGH_ADDR: min_high <= reg_wdata & `ACLTW_HIGH_BITS_MASK;
        `ACLTW_MIN_LOW_ADDR: min_low <= reg_wdata;
        `ACLTW_DELAY_ADDR: delay_ctl <= reg_wdata;
        `ACLTW_WAIT_ADDR: wait_ctl <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data one clock after the address; unmapped offsets read zero
  always_comb
  begin
    case (reg_addr)
      `ACLTW_MAX_LOW_ADDR: next_rdata = max_low;
      `ACLTW_MIN_HIGH_ADDR: next_rdata = min_high;
      `ACLTW_MIN_LOW_ADDR: next_rdata = min_low;
      `ACLTW_DELAY_ADDR: next_rdata = delay_ctl;
      `ACLTW_WAIT_ADDR: next_rdata = wait_ctl;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end

  // pin synchroniser; edge is taken only between the second and third stage
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end
    else
    begin
      pin_s1 <= third_general_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // [RL1] selected edge when enabled
  assign pin_edge = delay_ctl[`ACLTW_TRIG_SEL_BIT]
    && (delay_ctl[`ACLTW_EDGE_BIT] ? (pin_s2 && !pin_s3) : (!pin_s2 && pin_s3));

  // sequencer: holdoff drops pin edges during the delay, repeat off takes one pin edge per arming
  always_comb
  begin
    next_state = state;
    next_start = 1'b0;
    next_armed = trig_armed;
    next_result = result;
    next_above = above_max;
    next_below = below_min;
    delay_tif.load = 1'b0;
    delay_tif.cycles = 22'h000000;
    gap_tif.load = 1'b0;
    gap_tif.cycles = 22'h000000;
    if (reg_write && reg_addr == `ACLTW_DELAY_ADDR)
      next_armed = 1'b1;
    case (state)
      ACLTW_IDLE:
      begin
        if (sw_start && !delay_ctl[`ACLTW_TRIG_SEL_BIT])
        begin
          next_start = 1'b1;
          next_state = ACLTW_CONVERT;
        end
        // [RL2] delay timer loaded
        else if (pin_edge && trig_armed)
        begin
          delay_tif.load = 1'b1;
          delay_tif.cycles = 22'(delay_ctl[3:0] * DELAY_STEP_CYCLES);
          next_armed = delay_ctl[`ACLTW_REPEAT_BIT];
          next_state = ACLTW_DELAY;
        end
      end
      ACLTW_DELAY:
      begin
        if (delay_tif.done)
        begin
          next_start = 1'b1;
          next_state = ACLTW_CONVERT;
        end
        else if (pin_edge && !delay_ctl[`ACLTW_HOLDOFF_BIT] && trig_armed)
        begin
          delay_tif.load = 1'b1;
          delay_tif.cycles = 22'(delay_ctl[3:0] * DELAY_STEP_CYCLES);
        end
      end
      ACLTW_CONVERT:
      begin
        if (conv_done)
        begin
          // [RL6] result captured unsigned
          next_result = conv_result;
          // [RL5] limit compare
          next_above = conv_result > max_word;
          next_below = conv_result < min_word;
          if (multi_sample_mode && more_samples)
          begin
            // [RL3] gap before next sample
            gap_tif.load = 1'b1;
            gap_tif.cycles = 22'(gap_mult(wait_ctl[3:0]) * GAP_STEP_CYCLES);
            next_state = ACLTW_GAP;
          end
          else
            next_state = ACLTW_IDLE;
        end
      end
      ACLTW_GAP:
      begin
        if (gap_tif.done)
        begin
          next_start = 1'b1;
          next_state = ACLTW_CONVERT;
        end
      end
      default: next_state = ACLTW_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= ACLTW_IDLE;
      conv_start <= 1'b0;
      trig_armed <= 1'b1;
      result <= 11'h000;
      above_max <= 1'b0;
      below_min <= 1'b0;
    end
    else
    begin
      state <= next_state;
      conv_start <= next_start;
      trig_armed <= next_armed;
      result <= next_result;
      above_max <= next_above;
      below_min <= next_below;
    end
  end

  // countdown timers for trigger delay and sample gap
  acltw_timer u_delay_timer (.clk(clk), .reset(reset), .tif(delay_tif.timer));
  acltw_timer u_gap_timer (.clk(clk), .reset(reset), .tif(gap_tif.timer));

  pin_gated_a: assert property (@(posedge clk) disable iff (reset) // [RL1]
    (state == ACLTW_IDLE && !delay_ctl[`ACLTW_TRIG_SEL_BIT] && !sw_start) |=> !conv_start)
    else $error("conversion started with pin trigger off and no software start");

  delay_zero_a: assert property (@(posedge clk) disable iff (reset) // [RL2]
    (state == ACLTW_IDLE && pin_edge && trig_armed && !sw_start && delay_ctl[3:0] == 4'h0)
    |=> ##1 conv_start)
    else $error("zero trigger delay did not start conversion in two clocks");

  delay_step_a: assert property (@(posedge clk) disable iff (reset) // [RL2]
    (state == ACLTW_IDLE && pin_edge && trig_armed && !sw_start && delay_ctl[3:0] == 4'h1)
    |=> !conv_start [*2])
    else $error("one-step trigger delay ended early");

  gap_zero_a: assert property (@(posedge clk) disable iff (reset) // [RL3]
    (state == ACLTW_CONVERT && conv_done && multi_sample_mode && more_samples
    && wait_ctl[3:0] == 4'h0) |=> ##1 conv_start)
    else $error("zero sample gap did not restart at once");

  gap_wait_a: assert property (@(posedge clk) disable iff (reset) // [RL3]
    (state == ACLTW_CONVERT && conv_done && multi_sample_mode && more_samples
    && wait_ctl[3:0] != 4'h0) |=> !conv_start [*3])
    else $error("sample gap shorter than its step");

  limit_cmp_a: assert property (@(posedge clk) disable iff (reset) // [RL5]
    (state == ACLTW_CONVERT && conv_done) |=>
    (above_max == ($past(conv_result) > $past(max_word)))
    && (below_min == ($past(conv_result) < $past(min_word))))
    else $error("limit flags disagree with captured result");

  result_hold_a: assert property (@(posedge clk) disable iff (reset) // [RL6]
    (state == ACLTW_CONVERT && conv_done) |=> result == $past(conv_result))
    else $error("result not captured at conversion end");
endmodule : acltw_top

// ==== tb.sv ====
// self-checking bench for the converter setup block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acltw_pkg::*;
  logic clk, reset, reg_write, multi_sample_mode, more_samples, sw_start;
  logic third_general_pin, conv_done, conv_start, above_max, below_min;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] max_limit_high_bits;
  logic [10:0] conv_result, result;
  logic [1:0] analog2_pullup_code, pack_id_pullup_code;
  int fail_count = 0;
  int checks = 0;
  int lat [16];
  // gap multiples of the basic step, one per wait code
  int gap_mult [16] = '{0, 1, 2, 3, 4, 8, 12, 16, 32, 64, 96, 128, 256, 512, 768, 1024};

  // short steps keep the gap sweep within a few thousand cycles
  acltw_top #(.DELAY_STEP_CYCLES(2), .GAP_STEP_CYCLES(3)) DUT (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .max_limit_high_bits(max_limit_high_bits),
    .multi_sample_mode(multi_sample_mode), .more_samples(more_samples), .sw_start(sw_start),
    .third_general_pin(third_general_pin), .conv_done(conv_done), .conv_result(conv_result),
    .conv_start(conv_start), .result(result), .above_max(above_max), .below_min(below_min),
    .analog2_pullup_code(analog2_pullup_code), .pack_id_pullup_code(pack_id_pullup_code)
  );

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    tick();
    reg_write = 1'b0;
    // one idle edge so a following write never re-raises the strobe at once
    tick();
  endtask : wr

  // read data lags the address by one edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    tick();
    chk(reg_rdata, exp);
  endtask : rd_chk

  // bounded wait for a conversion start, returns cycles waited
  task automatic wait_start(output int n);
    n = 0;
    while (conv_start !== 1'b1 && n < 5000)
    begin
      tick();
      n++;
    end
    chk(n < 5000, 1'b1);
  endtask : wait_start

  task automatic quiet(input int n);
    repeat (n)
    begin
      tick();
      chk(conv_start, 1'b0);
    end
  endtask : quiet

  task automatic conv(input logic [10:0] res);
    conv_result = res;
    conv_done = 1'b1;
    tick();
    conv_done = 1'b0;
    tick(2);
  endtask : conv

  task automatic test_reset_values();
    for (int a = 8'h22; a <= 8'h26; a++)
      rd_chk(8'(a), 8'h00); // all zero after reset
    rd_chk(8'h30, 8'h00);
    chk(analog2_pullup_code, 2'h0);
    $display("test reset_values done");
  endtask : test_reset_values

  task automatic test_registers();
    wr(8'h22, 8'ha5);
    wr(8'h23, 8'hff);
    wr(8'h24, 8'h5a);
    wr(8'h26, 8'he3);
    wr(8'h30, 8'hff);
    rd_chk(8'h22, 8'ha5);
    rd_chk(8'h23, 8'h07); // only three low bits held
    rd_chk(8'h24, 8'h5a);
    rd_chk(8'h26, 8'he3);
    rd_chk(8'h30, 8'h00);
    chk(analog2_pullup_code, 2'h3);
    chk(pack_id_pullup_code, 2'h2);
    $display("test registers done");
  endtask : test_registers

  // strict compare against max 0x100 and min 0x010
  task automatic test_limits();
    int n;
    logic [10:0] res [4] = '{11'h101, 11'h100, 11'h00f, 11'h010};
    logic [1:0] flags [4] = '{2'b10, 2'b00, 2'b01, 2'b00};
    max_limit_high_bits = 3'h1;
    wr(8'h22, 8'h00);
    wr(8'h23, 8'h00);
    wr(8'h24, 8'h10);
    wr(8'h25, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      sw_start = 1'b1;
      tick();
      sw_start = 1'b0;
      wait_start(n);
      conv(res[i]);
      chk(result, res[i]); // eleven-bit result kept
      chk({above_max, below_min}, flags[i]); // limit flags
    end
    $display("test limits done");
  endtask : test_limits

  // latency differences between delay codes show the per-step weight
  task automatic test_pin_delay();
    int c [3] = '{1, 8, 15};
    int d [3];
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h25, 8'hd0 | 8'(c[i]));
      third_general_pin = 1'b1;
      wait_start(d[i]);
      conv(11'h000);
      third_general_pin = 1'b0;
      quiet(6);
    end
    chk(d[1] - d[0], 14); // top bit is eight steps
    chk(d[2] - d[0], 28); // full code fifteen steps
    sw_start = 1'b1;
    tick();
    sw_start = 1'b0;
    quiet(10); // software start ignored while pin selected
    $display("test pin_delay done");
  endtask : test_pin_delay

  // falling polarity, single-shot arming, holdoff, then pin deselected
  task automatic test_pin_modes();
    int n;
    int h [2];
    // pin raised with the trigger off, so no stray edge is left behind
    wr(8'h25, 8'h00);
    third_general_pin = 1'b1;
    tick(5);
    wr(8'h25, 8'h81);
    rd_chk(8'h25, 8'h81); // trigger controls held
    third_general_pin = 1'b0;
    wait_start(n); // falling edge triggers
    conv(11'h000);
    third_general_pin = 1'b1;
    tick(4);
    third_general_pin = 1'b0;
    quiet(12); // single shot until re-armed
    // second rising edge lands 14 clocks into a 30-clock delay
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h25, (i == 0) ? 8'hdf : 8'hff);
      third_general_pin = 1'b1;
      tick(10);
      third_general_pin = 1'b0;
      tick(4);
      third_general_pin = 1'b1;
      wait_start(h[i]); // delayed start arrives
      conv(11'h000);
      third_general_pin = 1'b0;
      quiet(6); // falling edge ignored in rising mode
    end
    chk(h[0] - h[1], 14); // delay restarts without holdoff
    wr(8'h25, 8'h00);
    third_general_pin = 1'b1;
    tick(4);
    third_general_pin = 1'b0;
    quiet(12); // pin inactive when not selected
    $display("test pin_modes done");
  endtask : test_pin_modes

  task automatic test_gap();
    int n;
    multi_sample_mode = 1'b1;
    more_samples = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      wr(8'h26, 8'(k));
      sw_start = 1'b1;
      tick();
      sw_start = 1'b0;
      wait_start(n);
      tick();
      conv_done = 1'b1;
      tick();
      conv_done = 1'b0;
      wait_start(lat[k]);
      more_samples = 1'b0;
      conv(11'h000);
      more_samples = 1'b1;
    end
    chk(lat[0] < lat[1], 1'b1); // code zero adds no wait
    for (int k = 2; k < 16; k++)
      chk(16'(lat[k] - lat[1]), 16'((gap_mult[k] - 1) * 3)); // coded sample gap
    multi_sample_mode = 1'b0;
    more_samples = 1'b1;
    sw_start = 1'b1;
    tick();
    sw_start = 1'b0;
    wait_start(n);
    conv(11'h000);
    quiet(10); // no follow-on sample outside multi mode
    $display("test gap done");
  endtask : test_gap

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // hang guard, well past the expected run length
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    max_limit_high_bits = 3'h0;
    multi_sample_mode = 1'b0;
    more_samples = 1'b0;
    sw_start = 1'b0;
    third_general_pin = 1'b0;
    conv_done = 1'b0;
    conv_result = 11'h000;
    tick(12);
    reset = 1'b0;
    tick(3);
    test_reset_values();
    test_registers();
    test_limits();
    test_pin_delay();
    test_pin_modes();
    test_gap();
    give_verdict();
  end
endmodule : tb
